//--- core/cmcr_top.sv
// Chip mode control registers and the polling, queue and hold sequencer they steer.
//
// Added by the designer: the plain strobed port.
`default_nettype none
module cmcr_top
  import cmcr_pkg::*;
#(
  parameter int unsigned HOP_CYCLES = CMCR_HOP_CYCLES
) (
  input  wire logic       CLK_SYS,
  input  wire logic       RST,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  input  wire logic       REG_WR,
  input  wire logic       REG_RD,
  output logic      [7:0] REG_RDATA,
  input  wire logic       END_OF_MESSAGE,
  input  wire logic       MESSAGE_TIMEOUT,
  input  wire logic       WAKEUP_FOUND,
  input  wire logic       FRAME_START,
  input  wire logic       QUEUE_LOCK_RELEASE,
  input  wire logic       NEW_CHANNEL,
  input  wire logic       SINGLE_CHANNEL,
  output logic      [1:0] ACTIVE_CONFIG,
  output logic            POLL_RESUME,
  output logic            NEXT_CHANNEL,
  output logic            QUEUE_CLEAR,
  output logic            QUEUE_LOCKED,
  output logic            RX_CHAIN_HALT,
  output logic            SLEEP_XTAL_HIGH_PREC,
  output logic            SERIAL_OUT_HIGH_DRIVE,
  output logic            CLOCK_OUTPUT_ENABLE,
  output logic            HOLD_CONFIG_STATE,
  output logic            SYNTH_REINIT,
  output logic            RX_INIT,
  output logic            RX_SLEEP,
  output logic            RX_SLAVE_RUN,
  output logic            SELF_POLLING
);
  if (HOP_CYCLES < 1) $error("HOP_CYCLES must be at least one");

  // ============================================================
  // Register file.
  logic [7:0]  poll_fifo_q;
  logic [7:0]  opmode_q;
  logic [7:0]  rdata_q;
  cmcr_state_t state_q;
  cmcr_state_t state_d;
  logic [1:0]  cfg_q;
  logic [1:0]  cfg_d;
  logic [1:0]  pend_cfg_q;
  logic [1:0]  pend_cfg_d;
  logic        lock_poll_q;
  logic        lock_poll_d;
  logic        chan_new_q;

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      poll_fifo_q <= CMCR_RST_POLL_FIFO;
      opmode_q    <= CMCR_RST_OPMODE;
    end else if (REG_WR) begin
      if (REG_ADDR == CMCR_OFS_POLL_FIFO) begin
        poll_fifo_q <= REG_WDATA & CMCR_POLL_FIFO_MASK;
      end
      if (REG_ADDR == CMCR_OFS_OPMODE) begin
        opmode_q <= REG_WDATA;
      end
    end
  end

  // Both control registers are write-only and read as zero; only status answers.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      rdata_q <= 8'h00;
    end else if (REG_RD && REG_ADDR == CMCR_OFS_STATUS) begin
      rdata_q <= {1'b0, state_q, cfg_q, QUEUE_LOCKED, HOLD_CONFIG_STATE};
    end else begin
      rdata_q <= 8'h00;
    end
  end
  assign REG_RDATA = rdata_q;

  wire msg_end_next  = poll_fifo_q[CMCR_B_MSG_END_CONT];
  wire timeout_next  = poll_fifo_q[CMCR_B_TIMEOUT_CONT];
  wire cycle_clear   = poll_fifo_q[CMCR_B_CYCLE_CLEAR];
  wire frame_clear   = poll_fifo_q[CMCR_B_FRAME_CLEAR];
  wire queue_lock_en = poll_fifo_q[CMCR_B_QUEUE_LOCK];
  wire synth_reinit  = opmode_q[CMCR_B_SYNTH_REINIT];
  wire hold_bit      = opmode_q[CMCR_B_HOLD];
  wire slave_rx_en   = opmode_q[CMCR_B_SLAVE_RX_EN];
  wire poll_mode     = opmode_q[CMCR_B_MODE_SEL];

  // ============================================================
  // Static outputs straight from register bits.
  assign SLEEP_XTAL_HIGH_PREC  = poll_fifo_q[CMCR_B_SLEEP_XTAL_HP];
  assign SERIAL_OUT_HIGH_DRIVE = opmode_q[CMCR_B_PAD_POWER];
  assign CLOCK_OUTPUT_ENABLE   = opmode_q[CMCR_B_CLKOUT_EN];

  // ============================================================
  // Hop timer.
  cmcr_hop_if hop ();
  cmcr_hop_timer #(
    .CYCLES (HOP_CYCLES)
  ) u_hop (
    .clk (CLK_SYS),
    .rst (RST),
    .hop (hop)
  );

  // ============================================================
  // Sequencer.
  logic clear_d;
  logic resume_d;
  logic next_ch_d;
  logic reinit_d;
  logic rx_init_d;
  logic clear_q;
  logic resume_q;
  logic next_ch_q;
  logic reinit_q;
  logic rx_init_q;

  always_comb begin
    state_d     = state_q;
    cfg_d       = cfg_q;
    pend_cfg_d  = pend_cfg_q;
    lock_poll_d = lock_poll_q;
    clear_d     = 1'b0;
    resume_d    = 1'b0;
    next_ch_d   = 1'b0;
    reinit_d    = 1'b0;
    rx_init_d   = 1'b0;
    hop.start   = 1'b0;
    unique case (state_q)
      CMCR_ST_SLEEP: begin
        if (poll_mode) begin
          state_d = CMCR_ST_POLL;
          cfg_d   = 2'h0;
        end else if (slave_rx_en) begin
          state_d   = CMCR_ST_SLAVE_RUN;
          clear_d   = cycle_clear;
          rx_init_d = 1'b1;
        end
      end
      CMCR_ST_SLAVE_RUN: begin
        if (poll_mode) begin
          state_d = CMCR_ST_POLL;
          cfg_d   = 2'h0;
        end else if (!slave_rx_en) begin
          state_d = CMCR_ST_SLEEP;
        end else if (hold_bit) begin
          state_d = CMCR_ST_HOLD;
        end else if (END_OF_MESSAGE && queue_lock_en) begin
          state_d     = CMCR_ST_LOCKED;
          lock_poll_d = 1'b0;
        end else if (FRAME_START) begin
          clear_d = frame_clear;
        end
      end
      CMCR_ST_HOLD: begin
        // Hold only leaves through its own bit, so a pending mode change waits for it.
        if (!hold_bit) begin
          if (synth_reinit && (chan_new_q || NEW_CHANNEL)) begin
            state_d   = CMCR_ST_HOP_WAIT;
            reinit_d  = 1'b1;
            hop.start = 1'b1;
          end else begin
            state_d   = CMCR_ST_SLAVE_RUN;
            rx_init_d = 1'b1;
          end
        end
      end
      CMCR_ST_HOP_WAIT: begin
        if (hop.done) begin
          state_d   = CMCR_ST_SLAVE_RUN;
          rx_init_d = 1'b1;
        end
      end
      CMCR_ST_POLL: begin
        if (!poll_mode) begin
          state_d = CMCR_ST_SLEEP;
        end else if (WAKEUP_FOUND) begin
          state_d   = CMCR_ST_POLL_RUN;
          clear_d   = cycle_clear;
          rx_init_d = 1'b1;
        end
      end
      CMCR_ST_POLL_RUN: begin
        if (!poll_mode) begin
          state_d = CMCR_ST_SLEEP;
        end else if (END_OF_MESSAGE) begin
          pend_cfg_d = msg_end_next ? cfg_q + 2'h1 : 2'h0;
          if (queue_lock_en) begin
            state_d     = CMCR_ST_LOCKED;
            lock_poll_d = 1'b1;
          end else begin
            state_d  = CMCR_ST_POLL;
            cfg_d    = msg_end_next ? cfg_q + 2'h1 : 2'h0;
            resume_d = 1'b1;
          end
        end else if (MESSAGE_TIMEOUT) begin
          state_d  = CMCR_ST_POLL;
          resume_d = 1'b1;
          if (!timeout_next) begin
            cfg_d = 2'h0;
          end else if (SINGLE_CHANNEL) begin
            cfg_d = cfg_q + 2'h1;
          end else begin
            next_ch_d = 1'b1;
          end
        end else if (FRAME_START) begin
          clear_d = frame_clear;
        end
      end
      CMCR_ST_LOCKED: begin
        // The chain stays halted even across a mode change until software releases it.
        if (QUEUE_LOCK_RELEASE) begin
          if (lock_poll_q) begin
            state_d  = CMCR_ST_POLL;
            cfg_d    = pend_cfg_q;
            resume_d = 1'b1;
          end else begin
            state_d = CMCR_ST_SLAVE_RUN;
          end
        end
      end
      default: begin
        state_d = CMCR_ST_SLEEP;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      state_q     <= CMCR_ST_SLEEP;
      cfg_q       <= 2'h0;
      pend_cfg_q  <= 2'h0;
      lock_poll_q <= 1'b0;
    end else begin
      state_q     <= state_d;
      cfg_q       <= cfg_d;
      pend_cfg_q  <= pend_cfg_d;
      lock_poll_q <= lock_poll_d;
    end
  end

  // A channel programmed during hold is remembered until hold is left.
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      chan_new_q <= 1'b0;
    end else if (state_q != CMCR_ST_HOLD) begin
      chan_new_q <= 1'b0;
    end else if (NEW_CHANNEL) begin
      chan_new_q <= 1'b1;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      clear_q   <= 1'b0;
      resume_q  <= 1'b0;
      next_ch_q <= 1'b0;
      reinit_q  <= 1'b0;
      rx_init_q <= 1'b0;
    end else begin
      clear_q   <= clear_d;
      resume_q  <= resume_d;
      next_ch_q <= next_ch_d;
      reinit_q  <= reinit_d;
      rx_init_q <= rx_init_d;
    end
  end

  // ============================================================
  // Outputs.
  assign ACTIVE_CONFIG     = poll_mode ? cfg_q : opmode_q[CMCR_B_CFG_SEL_HI:CMCR_B_CFG_SEL_LO];
  assign POLL_RESUME       = resume_q;
  assign NEXT_CHANNEL      = next_ch_q;
  assign QUEUE_CLEAR       = clear_q;
  assign QUEUE_LOCKED      = (state_q == CMCR_ST_LOCKED);
  assign RX_CHAIN_HALT     = (state_q == CMCR_ST_LOCKED) || hop.busy;
  assign HOLD_CONFIG_STATE = (state_q == CMCR_ST_HOLD);
  assign SYNTH_REINIT      = reinit_q;
  assign RX_INIT           = rx_init_q;
  assign RX_SLEEP          = (state_q == CMCR_ST_SLEEP);
  assign RX_SLAVE_RUN      = (state_q == CMCR_ST_SLAVE_RUN);
  assign SELF_POLLING      = (state_q == CMCR_ST_POLL) || (state_q == CMCR_ST_POLL_RUN);

  // ============================================================
  // Checks.
  logic [31:0] gap_q;
  always_ff @(posedge CLK_SYS) begin
    if (RST) begin
      gap_q <= 32'h0000_0000;
    end else if (SYNTH_REINIT) begin
      gap_q <= 32'h0000_0001;
    end else if (gap_q != 32'h0000_0000) begin
      gap_q <= gap_q + 32'h0000_0001;
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  chk_eom_next_cfg: assert property (
    state_q == CMCR_ST_POLL_RUN && poll_mode && END_OF_MESSAGE && !queue_lock_en && msg_end_next
    |=> cfg_q == $past(cfg_q) + 2'h1 && POLL_RESUME)
    else $error("message end did not advance configuration");
  chk_eom_cfg_a: assert property (
    state_q == CMCR_ST_POLL_RUN && poll_mode && END_OF_MESSAGE && !msg_end_next
    && !queue_lock_en |=> POLL_RESUME && cfg_q == 2'h0)
    else $error("message end did not return to configuration A");
  chk_timeout_channel: assert property (
    state_q == CMCR_ST_POLL_RUN && poll_mode && !END_OF_MESSAGE && MESSAGE_TIMEOUT
    && timeout_next && !SINGLE_CHANNEL
    |=> NEXT_CHANNEL && $stable(cfg_q) && SELF_POLLING)
    else $error("timeout did not step the RF channel");
  chk_single_channel: assert property (
    state_q == CMCR_ST_POLL_RUN && poll_mode && !END_OF_MESSAGE && MESSAGE_TIMEOUT
    && timeout_next && SINGLE_CHANNEL
    |=> !NEXT_CHANNEL && cfg_q == $past(cfg_q) + 2'h1)
    else $error("single channel timeout did not advance configuration");
  chk_slave_start_clear: assert property (
    $rose(RX_SLAVE_RUN) && $past(RX_SLEEP) |-> QUEUE_CLEAR == $past(cycle_clear))
    else $error("slave run start queue clear wrong");
  chk_wakeup_clear: assert property (
    state_q == CMCR_ST_POLL && poll_mode && WAKEUP_FOUND && cycle_clear
    |=> QUEUE_CLEAR && RX_INIT)
    else $error("wake-up did not clear the queue");
  chk_frame_clear: assert property (
    ((state_q == CMCR_ST_POLL_RUN && poll_mode && !MESSAGE_TIMEOUT)
    || (state_q == CMCR_ST_SLAVE_RUN && !poll_mode && slave_rx_en && !hold_bit))
    && FRAME_START && frame_clear && !END_OF_MESSAGE |=> QUEUE_CLEAR)
    else $error("frame start did not clear the queue");
  chk_lock_until_release: assert property (
    QUEUE_LOCKED && !QUEUE_LOCK_RELEASE |=> QUEUE_LOCKED && RX_CHAIN_HALT)
    else $error("queue lock dropped without release");
  chk_hop_wait_time: assert property (
    RX_INIT && $past(state_q) == CMCR_ST_HOP_WAIT |-> gap_q == HOP_CYCLES)
    else $error("receiver started before the hop time");
  chk_hold_entry: assert property (
    state_q == CMCR_ST_SLAVE_RUN && hold_bit && !poll_mode && slave_rx_en
    |=> HOLD_CONFIG_STATE [*2] or (HOLD_CONFIG_STATE ##1 !hold_bit))
    else $error("hold bit did not keep the configuration state");
  chk_clkout_write: assert property (
    REG_WR && REG_ADDR == CMCR_OFS_OPMODE
    |=> CLOCK_OUTPUT_ENABLE == $past(REG_WDATA[CMCR_B_CLKOUT_EN]))
    else $error("clock output enable does not follow its bit");
  chk_sleep_on_disable: assert property (
    RX_SLAVE_RUN && !poll_mode && !slave_rx_en |=> RX_SLEEP)
    else $error("slave receiver did not sleep");
  chk_upper_bits_zero: assert property (
    REG_WR && REG_ADDR == CMCR_OFS_POLL_FIFO |=> poll_fifo_q[7:6] == 2'h0
    && poll_fifo_q[5:0] == $past(REG_WDATA[5:0]))
    else $error("unused upper bits were stored");
endmodule
`default_nettype wire

//--- core/cmcr_pkg.sv
// Package: register map, field positions, reset values, states and timing of the mode control.
`default_nettype none
package cmcr_pkg;
  // ============================================================
  // Register map.
  localparam logic [7:0] CMCR_OFS_POLL_FIFO  = 8'ha5;
  localparam logic [7:0] CMCR_OFS_OPMODE     = 8'ha6;
  localparam logic [7:0] CMCR_OFS_STATUS     = 8'ha7;
  localparam logic [7:0] CMCR_RST_POLL_FIFO  = 8'h04;
  localparam logic [7:0] CMCR_RST_OPMODE     = 8'h10;
  localparam logic [7:0] CMCR_POLL_FIFO_MASK = 8'h3f;
  // ============================================================
  // Field positions of polling_and_fifo_control.
  localparam int unsigned CMCR_B_MSG_END_CONT  = 5;
  localparam int unsigned CMCR_B_TIMEOUT_CONT  = 4;
  localparam int unsigned CMCR_B_CYCLE_CLEAR   = 3;
  localparam int unsigned CMCR_B_FRAME_CLEAR   = 2;
  localparam int unsigned CMCR_B_QUEUE_LOCK    = 1;
  localparam int unsigned CMCR_B_SLEEP_XTAL_HP = 0;
  // ============================================================
  // Field positions of operating_mode_control.
  localparam int unsigned CMCR_B_PAD_POWER     = 7;
  localparam int unsigned CMCR_B_SYNTH_REINIT  = 6;
  localparam int unsigned CMCR_B_HOLD          = 5;
  localparam int unsigned CMCR_B_CLKOUT_EN     = 4;
  localparam int unsigned CMCR_B_CFG_SEL_HI    = 3;
  localparam int unsigned CMCR_B_CFG_SEL_LO    = 2;
  localparam int unsigned CMCR_B_SLAVE_RX_EN   = 1;
  localparam int unsigned CMCR_B_MODE_SEL      = 0;
  // ============================================================
  // Timing: channel hop wait, a least time rounded up to whole cycles.
  localparam int unsigned CMCR_CLK_PERIOD_PS = 5000;
  localparam int unsigned CMCR_HOP_TIME_PS   = 10000000;
  localparam int unsigned CMCR_HOP_CYCLES    =
    (CMCR_HOP_TIME_PS + CMCR_CLK_PERIOD_PS - 1) / CMCR_CLK_PERIOD_PS;
  // ============================================================
  // Sequencer states.
  typedef enum logic [2:0] {
    CMCR_ST_SLEEP,
    CMCR_ST_SLAVE_RUN,
    CMCR_ST_HOLD,
    CMCR_ST_HOP_WAIT,
    CMCR_ST_POLL,
    CMCR_ST_POLL_RUN,
    CMCR_ST_LOCKED
  } cmcr_state_t;
endpackage
`default_nettype wire

//--- core/cmcr_hop_if.sv
// Interface: start and finish of the channel hop wait between sequencer and timer.
`default_nettype none
interface cmcr_hop_if;
  logic start;
  logic busy;
  logic done;
  modport seq (output start, input busy, input done);
  modport tmr (input start, output busy, output done);
endinterface
`default_nettype wire

//--- core/cmcr_hop_timer.sv
// Channel hop wait timer: counts a fixed number of cycles after each start.
`default_nettype none
module cmcr_hop_timer #(
  parameter int unsigned CYCLES = 2000
) (
  input  wire logic  clk,
  input  wire logic  rst,
  cmcr_hop_if.tmr    hop
);
  localparam int unsigned CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;

  logic [CW-1:0] cnt_q;
  logic          busy_q;

  if (CYCLES < 1) $error("hop wait must be at least one cycle");

  // ============================================================
  // Counter.
  // A start while busy restarts the wait, so the receiver never starts early.
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
    end else if (hop.start) begin
      cnt_q  <= CW'(CYCLES - 1);
      busy_q <= 1'b1;
    end else if (busy_q && cnt_q == '0) begin
      busy_q <= 1'b0;
    end else if (busy_q) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign hop.busy = busy_q;
  assign hop.done = busy_q && (cnt_q == '0);
endmodule
`default_nettype wire

//--- dv/cmcr_host_model.sv
// Host model: issues register write and read cycles to the mode control block.
`default_nettype none
module cmcr_host_model (
  input  wire logic       clk,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // ============================================================
  // Bus cycles.
  // Once released, the address shows its inverse, and after a write the data too, so that stale values never look valid.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask
endmodule
`default_nettype wire

//--- dv/testbench.sv
// Testbench: random and corner-case stimulus for the chip mode control registers.
`default_nettype none
module testbench
  import cmcr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned HOP = 4;
  localparam int LIMIT = 20000;
  logic       clk;
  logic       rst;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       wr;
  logic       rd;
  logic [5:0] ev;
  logic       single_ch;
  logic [1:0] act_cfg;
  wire  [4:0] pls;
  logic       locked;
  logic       halt;
  logic       xtal;
  logic       pad;
  logic       clko;
  logic       hold;
  logic       rx_sleep;
  logic       rx_slave;
  logic       self_poll;
  int         n [5];
  int         bad_count;
  int         cmp_count;
  int         cycles;
  cmcr_top #(.HOP_CYCLES(HOP)) dut_u (
    .CLK_SYS(clk), .RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
    .REG_RD(rd), .REG_RDATA(rdata), .END_OF_MESSAGE(ev[0]), .MESSAGE_TIMEOUT(ev[1]),
    .WAKEUP_FOUND(ev[2]), .FRAME_START(ev[3]), .QUEUE_LOCK_RELEASE(ev[4]),
    .NEW_CHANNEL(ev[5]), .SINGLE_CHANNEL(single_ch), .ACTIVE_CONFIG(act_cfg),
    .POLL_RESUME(pls[0]), .NEXT_CHANNEL(pls[1]), .QUEUE_CLEAR(pls[2]),
    .QUEUE_LOCKED(locked), .RX_CHAIN_HALT(halt), .SLEEP_XTAL_HIGH_PREC(xtal),
    .SERIAL_OUT_HIGH_DRIVE(pad), .CLOCK_OUTPUT_ENABLE(clko), .HOLD_CONFIG_STATE(hold),
    .SYNTH_REINIT(pls[3]), .RX_INIT(pls[4]), .RX_SLEEP(rx_sleep), .RX_SLAVE_RUN(rx_slave),
    .SELF_POLLING(self_poll)
  );
  cmcr_host_model host_u (
    .clk(clk), .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd),
    .reg_rdata(rdata)
  );
  // ============================================================
  // Clock, pulse counters and hang guard.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    for (int i = 0; i < 5; i++) begin
      if (pls[i] === 1'b1) n[i]++;
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      bad_count++;
      conclude();
    end
  end
  // ============================================================
  // Shared tasks and expectation functions.
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic pulse(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev[i] <= 1'b0;
  endtask
  task automatic settle();
    repeat (3) @(posedge clk);
    @(negedge clk);
  endtask
  // Counts are cleared off the rising edge so the counter process never races it.
  task automatic zero();
    @(negedge clk);
    n = '{default: 0};
  endtask
  function automatic logic [1:0] resume_cfg(logic [1:0] c, logic cont);
    return cont ? c + 2'd1 : 2'd0;
  endfunction
  task automatic conclude();
    if (bad_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ============================================================
  // Main sequence.
  initial begin
    logic [7:0] r;
    logic [7:0] v;
    logic [7:0] base;
    logic [1:0] cfg;
    logic [3:0] k;
    rst = 1'b1;
    ev = '0;
    single_ch = 1'b0;
    bad_count = 0;
    cmp_count = 0;
    cycles = 0;
    n = '{default: 0};
    void'($urandom(68));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk(8'(clko), 8'h01);
    chk(8'(rx_sleep), 8'h01);
    host_u.rd(CMCR_OFS_POLL_FIFO, r);
    chk(r, 8'h00);
    host_u.rd(8'h3c, r);
    chk(r, 8'h00);
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom);
      r = 8'($urandom);
      host_u.wr(CMCR_OFS_OPMODE, v & 8'h90);
      host_u.wr(CMCR_OFS_POLL_FIFO, r);
      settle();
      chk(8'(pad), 8'(v[7]));
      chk(8'(clko), 8'(v[4]));
      chk(8'(xtal), 8'(r[0]));
      chk(8'(rx_sleep), 8'h01);
    end
    // Hold has no effect outside slave run.
    host_u.wr(CMCR_OFS_OPMODE, 8'h30);
    settle();
    chk(8'(hold), 8'h00);
    base = 8'h12 | {4'h0, 2'($urandom), 2'b00};
    host_u.wr(CMCR_OFS_POLL_FIFO, 8'hcc);
    zero();
    host_u.wr(CMCR_OFS_OPMODE, base);
    settle();
    chk(8'(rx_slave), 8'h01);
    chk(8'(act_cfg), 8'(base[3:2]));
    chk(8'(n[2]), 8'h01);
    zero();
    pulse(3);
    settle();
    chk(8'(n[2]), 8'h01);
    host_u.wr(CMCR_OFS_POLL_FIFO, 8'h02);
    zero();
    pulse(3);
    settle();
    chk(8'(n[2]), 8'h00);
    pulse(0);
    settle();
    chk(8'(locked), 8'h01);
    chk(8'(halt), 8'h01);
    host_u.rd(CMCR_OFS_STATUS, r);
    chk(r, {1'b0, 3'(CMCR_ST_LOCKED), 2'b00, 2'b10});
    pulse(4);
    settle();
    chk(8'(locked), 8'h00);
    chk(8'(rx_slave), 8'h01);
    host_u.wr(CMCR_OFS_OPMODE, base | 8'h60);
    settle();
    chk(8'(hold), 8'h01);
    zero();
    pulse(5);
    host_u.wr(CMCR_OFS_OPMODE, base | 8'h40);
    repeat (2) @(negedge clk);
    chk(8'(halt), 8'h01);
    chk(8'(n[4]), 8'h00);
    repeat (HOP + 3) @(posedge clk);
    @(negedge clk);
    chk(8'(n[3]), 8'h01);
    chk(8'(n[4]), 8'h01);
    chk(8'(halt), 8'h00);
    host_u.wr(CMCR_OFS_OPMODE, 8'h10);
    settle();
    chk(8'(rx_sleep), 8'h01);
    // Self polling: the first sixteen passes cover every code, then random ones.
    host_u.wr(CMCR_OFS_POLL_FIFO, 8'h08);
    host_u.wr(CMCR_OFS_OPMODE, 8'h11);
    zero();
    pulse(2);
    settle();
    chk(8'(n[2]), 8'h01);
    chk(8'(self_poll), 8'h01);
    cfg = 2'd0;
    for (int i = 0; i < 24; i++) begin
      k = (i < 16) ? 4'(i) : 4'($urandom);
      host_u.wr(CMCR_OFS_POLL_FIFO, {2'b00, k[1:0], 4'h0});
      single_ch <= k[3];
      pulse(2);
      zero();
      pulse(k[2] ? 0 : 1);
      settle();
      chk(8'(n[0]), 8'h01);
      if (k[2]) begin
        cfg = resume_cfg(cfg, k[1]);
        chk(8'(act_cfg), 8'(cfg));
      end else if (k[0] && k[3]) begin
        cfg = resume_cfg(cfg, 1'b1);
        chk(8'(act_cfg), 8'(cfg));
        chk(8'(n[1]), 8'h00);
      end else begin
        cfg = k[0] ? cfg : 2'd0;
        chk(8'(act_cfg), 8'(cfg));
        chk(8'(n[1]), 8'(k[0]));
      end
    end
    conclude();
  end
endmodule
`default_nettype wire
